// *** core/mft_timer.sv ***
`timescale 1ns/1ps
`include "mft_regs.svh"
// How it works
// - bus clock divided by four drives an eight stage counter, overflow every 1024.
// - overflow flag sets when counter wraps from all ones to zero.
// - overflow request while overflow flag and its enable bit 5 are set.
// - writing zero to the overflow flag bit clears it.
// - four stage divider after counter gives base tick every 16384 clocks.
// - rate select codes 0..3 divide base tick by 1, 2, 4, 8.
// - periodic flag sets per selected tick; request when flag and enable set.
// - writing zero clears periodic flag; writing one leaves it unchanged.
// - watchdog times out after eight selected ticks; at least seven periods guaranteed.
// - watchdog timeout asserts an internal reset request to the core.
// - software writes zero to bit 0 of service address; count clears.
// - watchdog always enabled, no disable, keeps counting in wait mode.
// - edge-only bit 3 picks falling edge, else low level plus falling edge.
// - counter value readable, read only, cleared by reset.
// - reset loads flags and enables zero, rate select as 11.
// - overflow and periodic sources share one request line and vector.
// - in level mode a low external line keeps requesting after service.
module mft_timer import mft_pkg::*; #(
  parameter int PRESCALE_W = `MFT_PRESCALE_W,
  parameter int RIPPLE_W = `MFT_RIPPLE_W,
  parameter int RTI_DIV_W = `MFT_RTI_DIV_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [`MFT_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // external interrupt pin and core handshake
  input wire logic ext_irq_n_pin,
  input wire logic ext_irq_ack,
  output logic ext_irq_req,
  // requests to the core
  output logic timer_irq_req,
  output logic watchdog_reset_req
);
  logic [PRESCALE_W-1:0] prescale;
  logic [RIPPLE_W-1:0] timer_count_value;
  logic [RTI_DIV_W-1:0] rti_div;
  logic [`MFT_RATE_DIV_W-1:0] rate_div;
  logic [`MFT_WDOG_W-1:0] wdog_count;
  logic overflow_flag;
  logic periodic_tick_flag;
  logic overflow_irq_enable;
  logic periodic_irq_enable;
  logic ext_irq_edge_only;
  logic rate_select_high;
  logic rate_select_low;
  // reset image kept whole so each field picks its own bit
  localparam logic [7:0] CSR_RST = `MFT_CSR_RESET;

  function automatic logic hit(input logic [`MFT_ADDR_W-1:0] a,
                               input logic [`MFT_ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  wire csr_wr = reg_wr & hit(reg_addr, `MFT_CSR_ADDR);
  wire wdog_wr = reg_wr & hit(reg_addr, `MFT_WDOG_ADDR);
  wire csr_rd = reg_rd & hit(reg_addr, `MFT_CSR_ADDR);
  wire cnt_rd = reg_rd & hit(reg_addr, `MFT_CNT_ADDR);

  wire pre_tc = &prescale;
  wire ovf_tick = pre_tc & (&timer_count_value);
  wire base_tick = ovf_tick & (&rti_div);
  mft_rate_t rate;
  assign rate = mft_rate_t'({rate_select_high, rate_select_low});
  logic sel_tick;
  always_comb begin
    sel_tick = 1'b0;
    case (rate)
      MFT_RATE_DIV1: sel_tick = base_tick;
      MFT_RATE_DIV2: sel_tick = base_tick & rate_div[0];
      MFT_RATE_DIV4: sel_tick = base_tick & (&rate_div[1:0]);
      MFT_RATE_DIV8: sel_tick = base_tick & (&rate_div);
      default: sel_tick = 1'b0;
    endcase
  end

  // service needs a zero in bit 0 only; other bits don't care
  wire wdog_service = wdog_wr & ~reg_wdata[0];
  // clear from the count, then eight ticks: first partial period costs up to one
  wire wdog_expire = sel_tick & (&wdog_count) & ~wdog_service;

  // set wins over a same cycle clear
  wire next_ovf = ovf_tick | (overflow_flag &
                  ~(csr_wr & ~reg_wdata[`MFT_BIT_OVF]));
  wire next_per = sel_tick | (periodic_tick_flag &
                  ~(csr_wr & ~reg_wdata[`MFT_BIT_PER]));
  wire next_ovf_ie = csr_wr ? reg_wdata[`MFT_BIT_OVF_IE] : overflow_irq_enable;
  wire next_per_ie = csr_wr ? reg_wdata[`MFT_BIT_PER_IE] : periodic_irq_enable;
  // one shared request line, the handler reads both flags
  wire next_timer_irq = (next_ovf & next_ovf_ie) | (next_per & next_per_ie);

  wire [7:0] csr_value;
  assign csr_value = {overflow_flag, periodic_tick_flag, overflow_irq_enable,
                      periodic_irq_enable, ext_irq_edge_only, 1'b0,
                      rate_select_high, rate_select_low};
  wire [7:0] next_rdata = csr_rd ? csr_value :
                          cnt_rd ? 8'(timer_count_value) : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prescale <= '0;
      timer_count_value <= '0;
      rti_div <= '0;
      rate_div <= '0;
    end else begin
      prescale <= prescale + 1'b1;
      if (pre_tc) begin
        timer_count_value <= timer_count_value + 1'b1;
      end
      if (ovf_tick) begin
        rti_div <= rti_div + 1'b1;
      end
      if (base_tick) begin
        rate_div <= rate_div + 1'b1;
      end
    end
  end

  // the watchdog block has no enable input at all
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdog_count <= '0;
      watchdog_reset_req <= 1'b0;
    end else begin
      if (wdog_service) begin
        wdog_count <= '0;
      end else if (sel_tick) begin
        wdog_count <= wdog_count + 1'b1;
      end
      watchdog_reset_req <= wdog_expire;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overflow_flag <= CSR_RST[`MFT_BIT_OVF];
      periodic_tick_flag <= CSR_RST[`MFT_BIT_PER];
      overflow_irq_enable <= CSR_RST[`MFT_BIT_OVF_IE];
      periodic_irq_enable <= CSR_RST[`MFT_BIT_PER_IE];
      ext_irq_edge_only <= CSR_RST[`MFT_BIT_EDGE_ONLY];
      rate_select_high <= CSR_RST[`MFT_BIT_RATE_HI];
      rate_select_low <= CSR_RST[`MFT_BIT_RATE_LO];
      timer_irq_req <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      overflow_flag <= next_ovf;
      periodic_tick_flag <= next_per;
      overflow_irq_enable <= next_ovf_ie;
      periodic_irq_enable <= next_per_ie;
      timer_irq_req <= next_timer_irq;
      reg_rdata <= next_rdata;
      if (csr_wr) begin
        ext_irq_edge_only <= reg_wdata[`MFT_BIT_EDGE_ONLY];
        // rate change mid period alters the watchdog window in progress; a faster rate shortens it
        rate_select_high <= reg_wdata[`MFT_BIT_RATE_HI];
        rate_select_low <= reg_wdata[`MFT_BIT_RATE_LO];
      end
    end
  end

  mft_ext_irq u_ext_irq (
    .clk_sys(clk_sys),
    .rst(rst),
    .ext_irq_n_pin(ext_irq_n_pin),
    .ext_irq_edge_only(ext_irq_edge_only),
    .ext_irq_ack(ext_irq_ack),
    .ext_irq_req(ext_irq_req)
  );
endmodule : mft_timer

// *** core/mft_regs.svh ***
`ifndef MFT_REGS_SVH
`define MFT_REGS_SVH
`define MFT_ADDR_W 16
`define MFT_CSR_ADDR 16'h0008
`define MFT_CNT_ADDR 16'h0009
`define MFT_WDOG_ADDR 16'h3ff0
`define MFT_CSR_RESET 8'h03
`define MFT_BIT_OVF 7
`define MFT_BIT_PER 6
`define MFT_BIT_OVF_IE 5
`define MFT_BIT_PER_IE 4
`define MFT_BIT_EDGE_ONLY 3
`define MFT_BIT_RATE_HI 1
`define MFT_BIT_RATE_LO 0
`define MFT_PRESCALE_W 2
`define MFT_RIPPLE_W 8
`define MFT_RTI_DIV_W 4
`define MFT_RATE_DIV_W 3
`define MFT_WDOG_W 3
`endif

// *** core/mft_pkg.sv ***
package mft_pkg;
  typedef enum logic [1:0] {
    MFT_RATE_DIV1,
    MFT_RATE_DIV2,
    MFT_RATE_DIV4,
    MFT_RATE_DIV8
  } mft_rate_t;
  typedef enum logic [1:0] {
    MFT_EXT_IDLE,
    MFT_EXT_PENDING
  } mft_ext_state_t;
endpackage : mft_pkg

// *** core/mft_ext_irq.sv ***
`timescale 1ns/1ps
`include "mft_regs.svh"
module mft_ext_irq import mft_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pin and option
  input wire logic ext_irq_n_pin,
  input wire logic ext_irq_edge_only,
  // core handshake
  input wire logic ext_irq_ack,
  output logic ext_irq_req
);
  logic sync_a;
  logic sync_b;
  logic last_b;
  mft_ext_state_t state;
  wire fall = last_b & ~sync_b;
  wire level_low = ~sync_b & ~ext_irq_edge_only;
  // a fall during service merges into the pending request; only one in the ack cycle is kept
  wire next_req = fall | level_low | ((state == MFT_EXT_PENDING) & ~ext_irq_ack);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      last_b <= 1'b1;
      ext_irq_req <= 1'b0;
      state <= MFT_EXT_IDLE;
    end else begin
      sync_a <= ext_irq_n_pin;
      sync_b <= sync_a;
      last_b <= sync_b;
      ext_irq_req <= next_req;
      case (state)
        MFT_EXT_IDLE: state <= next_req ? MFT_EXT_PENDING : MFT_EXT_IDLE;
        MFT_EXT_PENDING: state <= next_req ? MFT_EXT_PENDING : MFT_EXT_IDLE;
        default: state <= MFT_EXT_IDLE;
      endcase
    end
  end
endmodule : mft_ext_irq

// *** sim/mft_timer_props.sv ***
`timescale 1ns/1ps
`include "mft_regs.svh"
module mft_timer_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [`MFT_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // interrupt and reset lines
  input wire logic ext_irq_n_pin,
  input wire logic ext_irq_ack,
  input wire logic ext_irq_req,
  input wire logic timer_irq_req,
  input wire logic watchdog_reset_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire csr_sel = reg_addr == `MFT_CSR_ADDR;
  wire svc = reg_wr && reg_addr == `MFT_WDOG_ADDR && !reg_wdata[0];
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_bit2_zero: assert property ($past(reg_rd) && $past(reg_addr) == `MFT_CSR_ADDR
    |-> !reg_rdata[2]) else $error("bit 2 not zero");
  chk_wdog_pulse: assert property (watchdog_reset_req |=> !watchdog_reset_req)
    else $error("reset request too long");
  chk_wdog_service: assert property (svc |-> ##2 !watchdog_reset_req [*8])
    else $error("reset right after service");
  chk_irq_hold: assert property (timer_irq_req && !reg_wr |=> timer_irq_req)
    else $error("timer request dropped");
  chk_irq_clear: assert property (reg_wr && csr_sel && reg_wdata[5:4] == 2'b00
    |=> !timer_irq_req) else $error("request with enables off");
  chk_ext_fall: assert property ($fell(ext_irq_n_pin) |-> ##[1:5] ext_irq_req)
    else $error("falling edge missed");
  chk_ext_ack: assert property (ext_irq_n_pin [*6] ##0 ext_irq_ack |=> !ext_irq_req)
    else $error("request kept after ack");
  cov_wdog: cover property (watchdog_reset_req);
  cov_ack: cover property (ext_irq_ack && ext_irq_req);
  cov_irq: cover property ($rose(timer_irq_req));
endmodule : mft_timer_props
bind mft_timer mft_timer_props u_props (
  .clk_sys(clk_sys),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .ext_irq_n_pin(ext_irq_n_pin),
  .ext_irq_ack(ext_irq_ack),
  .ext_irq_req(ext_irq_req),
  .timer_irq_req(timer_irq_req),
  .watchdog_reset_req(watchdog_reset_req)
);

// *** sim/mft_core_model.sv ***
`timescale 1ns/1ps
module mft_core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // requests and acknowledge
  input wire logic ext_irq_req,
  input wire logic watchdog_reset_req,
  input wire logic slow,
  output logic ext_irq_ack
);
  int services;
  int resets;
  int w;
  // handler entry latency before the ack; a held line is served again
  always_ff @(posedge clk_sys) begin
    ext_irq_ack <= 1'b0;
    if (rst) begin
      w <= 0;
    end else if (ext_irq_req && !ext_irq_ack) begin
      w <= (w == (slow ? 8 : 2)) ? 0 : w + 1;
      if (w == (slow ? 8 : 2)) begin
        ext_irq_ack <= 1'b1;
        services <= services + 1;
      end
    end
    if (watchdog_reset_req) begin
      resets <= resets + 1;
    end
  end
endmodule : mft_core_model

// *** sim/mft_timer_tb.sv ***
`timescale 1ns/1ps
`include "mft_regs.svh"
module mft_timer_tb;
  localparam int OVF = 1 << 5;
  localparam int BASE = OVF << 1;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_irq_n_pin = 1'b1;
  logic slow = 1'b0;
  logic [`MFT_ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] csr;
  logic ext_irq_ack, ext_irq_req, timer_irq_req, watchdog_reset_req;
  int failures, compares, cyc, t0, n, per;
  mft_timer #(.PRESCALE_W(1), .RIPPLE_W(4), .RTI_DIV_W(1)) dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ext_irq_n_pin(ext_irq_n_pin),
    .ext_irq_ack(ext_irq_ack),
    .ext_irq_req(ext_irq_req),
    .timer_irq_req(timer_irq_req),
    .watchdog_reset_req(watchdog_reset_req)
  );
  mft_core_model model (
    .clk_sys(clk_sys),
    .rst(rst),
    .ext_irq_req(ext_irq_req),
    .watchdog_reset_req(watchdog_reset_req),
    .slow(slow),
    .ext_irq_ack(ext_irq_ack)
  );
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // longest run is well under this
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      failures++;
      print_verdict();
    end
  end
  // callers hand over settled values; arguments are copied at the call
  task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got & m, exp & m);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp, m);
  endtask : rd
  task wait_irq(input int lim, output int t);
    t = cyc + lim;
    do @(negedge clk_sys); while (timer_irq_req !== 1'b1 && cyc < t);
    t = cyc;
  endtask : wait_irq
  task pin_low(input int len);
    ext_irq_n_pin <= 1'b0;
    repeat (len) @(posedge clk_sys);
    ext_irq_n_pin <= 1'b1;
    repeat (30) @(posedge clk_sys);
  endtask : pin_low
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`MFT_CNT_ADDR, 8'h00, 8'hfe);
    rd(`MFT_CSR_ADDR, 8'h03, 8'hff);
    rd(16'h0010, 8'h00, 8'hff);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      csr = (i == 0) ? 8'h24 : 8'h14 | 8'(i - 1);
      per = (i == 0) ? OVF : BASE << (i - 1);
      wr(`MFT_WDOG_ADDR, 8'h00);
      wr(`MFT_CSR_ADDR, csr);
      rd(`MFT_CSR_ADDR, csr & 8'h3b, 8'h3f);
      wait_irq(2 * per + 8, t0);
      wr(`MFT_CSR_ADDR, csr);
      wait_irq(2 * per + 8, n);
      chk(n - t0, per, '1);
      wr(`MFT_CSR_ADDR, csr | 8'hc0);
      @(negedge clk_sys);
      chk(timer_irq_req, 1, 1);
    end
    $display("test rates done");
    wr(`MFT_WDOG_ADDR, 8'h00);
    wr(`MFT_CSR_ADDR, 8'h00);
    repeat (3) begin
      repeat (5 * BASE) @(posedge clk_sys);
      wr(`MFT_WDOG_ADDR, 8'h00);
    end
    t0 = cyc;
    do @(negedge clk_sys); while (watchdog_reset_req !== 1'b1 && cyc < t0 + 10 * BASE);
    chk(cyc - t0 >= 7 * BASE && cyc - t0 <= 8 * BASE + 4, 1, 1);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk(model.resets, 1, '1);
    rd(`MFT_CSR_ADDR, 8'h03, 8'hff);
    $display("test watchdog done");
    wr(`MFT_CSR_ADDR, 8'h08);
    slow <= 1'b1;
    pin_low(3);
    chk(model.services, 1, '1);
    pin_low(40);
    chk(model.services, 2, '1);
    slow <= 1'b0;
    wr(`MFT_CSR_ADDR, 8'h00);
    pin_low(40);
    chk(model.services > 7, 1, 1);
    $display("test external done");
    print_verdict();
  end
endmodule : mft_timer_tb
